/* hdl/addressing_mode_ea_unit.sv */
// Instruction-length decode and effective-address generator for the core.
`timescale 1ns/1ps
module addressing_mode_ea_unit
  #(
    parameter int ADDR_WIDTH = 16
  )
  (
    // Clock and reset.
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Decode request from the sequencer.
    input  wire logic              start,
    input  wire ea_pkg::addr_mode_t mode,
    input  wire logic              use_second_index,
    input  wire logic              rmw_op,
    input  wire logic [ADDR_WIDTH-1:0] pc_opcode,
    input  wire logic [7:0]        index_x,
    input  wire logic [7:0]        index_y,
    // Memory read port.
    output logic                   mem_rd,
    output logic [ADDR_WIDTH-1:0]  mem_addr,
    input  wire logic              mem_valid,
    input  wire logic [7:0]        mem_rdata,
    // Result.
    output logic                   busy,
    output logic                   done,
    output logic                   mode_error,
    output ea_pkg::ea_kind_t       ea_kind,
    output logic [ADDR_WIDTH-1:0]  ea,
    output logic [7:0]             literal,
    output logic [ADDR_WIDTH-1:0]  next_pc,
    output logic [2:0]             instr_extra
  );
  import ea_pkg::*;

  if (ADDR_WIDTH != ADDR_W)
  begin : g_width_check
    $error("ADDR_WIDTH must equal the core address width.");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH_B1,
    ST_FETCH_B2,
    ST_PTR_HI,
    ST_PTR_LO,
    ST_DONE
  } ea_state_t;

  ea_state_t              state;
  addr_mode_t             cur_mode;
  logic [7:0]             cur_index;
  logic [ADDR_WIDTH-1:0]  fetch_pc;
  logic [7:0]             byte1;
  logic [7:0]             ptr_hi;
  logic [2:0]             extra_len;
  logic                   long_form;
  logic                   needs_ptr;
  logic                   ptr_word;
  logic [1:0]             stream_bytes;
  logic [ADDR_WIDTH-1:0]  next_ea;
  ea_kind_t               next_kind;

  // Bytes that follow the opcode, per mode; Y no-offset needs its prebyte.
  always_comb
  begin
    unique case (mode)
      MODE_INHERENT:          extra_len = 3'd0;
      MODE_IMMEDIATE:         extra_len = 3'd1;
      MODE_DIRECT_SHORT:      extra_len = 3'd1;
      MODE_DIRECT_LONG:       extra_len = 3'd2;
      MODE_INDEXED_NONE:      extra_len = {2'b00, use_second_index};
      MODE_INDEXED_SHORT:     extra_len = 3'd1;
      MODE_INDEXED_LONG:      extra_len = 3'd2;
      MODE_BIT_INDIRECT_REL:  extra_len = 3'd3;
      MODE_RELATIVE_DIRECT,
      MODE_BIT_DIRECT:        extra_len = 3'd1;
      default:                extra_len = 3'd2;
    endcase
  end

  // Long forms are refused for read-modify-write operations.
  always_comb
  begin
    long_form = (mode == MODE_DIRECT_LONG) || (mode == MODE_INDEXED_LONG) ||
                (mode == MODE_INDIRECT_LONG) || (mode == MODE_IND_INDEXED_LONG);
  end

  // Stream bytes to fetch and pointer kind for the current mode.
  always_comb
  begin
    stream_bytes = 2'd1;
    needs_ptr    = 1'b0;
    ptr_word     = 1'b0;
    case (cur_mode)
      MODE_DIRECT_LONG,
      MODE_INDEXED_LONG:      stream_bytes = 2'd2;
      MODE_INHERENT,
      MODE_INDEXED_NONE:      stream_bytes = 2'd0;
      MODE_INDIRECT_SHORT,
      MODE_IND_INDEXED_SHORT,
      MODE_RELATIVE_INDIRECT,
      MODE_BIT_INDIRECT,
      MODE_BIT_INDIRECT_REL:  needs_ptr = 1'b1;
      MODE_INDIRECT_LONG,
      MODE_IND_INDEXED_LONG:
      begin
        needs_ptr = 1'b1;
        ptr_word  = 1'b1;
      end
      default:                stream_bytes = 2'd1;
    endcase
  end

  // Sequencer: address bytes after the opcode, then pointer bytes.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (start && !(rmw_op && long_form))
            state <= ST_FETCH_B1;
        ST_FETCH_B1:
          if (stream_bytes == 2'd0)
            state <= ST_DONE;
          else if (mem_valid)
          begin
            if (stream_bytes == 2'd2)
              state <= ST_FETCH_B2;
            else if (needs_ptr)
              state <= ptr_word ? ST_PTR_HI : ST_PTR_LO;
            else
              state <= ST_DONE;
          end
        ST_FETCH_B2:
          if (mem_valid)
            state <= ST_DONE;
        ST_PTR_HI:
          if (mem_valid)
            state <= ST_PTR_LO;
        ST_PTR_LO:
          if (mem_valid)
            state <= ST_DONE;
        ST_DONE:
          state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Request capture.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cur_mode  <= MODE_INHERENT;
      cur_index <= 8'h00;
      fetch_pc  <= '0;
      next_pc   <= '0;
      instr_extra <= 3'd0;
    end
    else if (state == ST_IDLE && start)
    begin
      cur_mode    <= mode;
      cur_index   <= use_second_index ? index_y : index_x;
      fetch_pc    <= pc_opcode + 16'h0001;
      instr_extra <= extra_len;
      next_pc     <= pc_opcode + 16'h0001 + {13'h0000, extra_len};
    end
  end

  // Captured stream and pointer bytes.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      byte1  <= 8'h00;
      ptr_hi <= 8'h00;
    end
    else if (mem_valid && state == ST_FETCH_B1)
      byte1 <= mem_rdata;
    else if (mem_valid && state == ST_PTR_HI)
      ptr_hi <= mem_rdata;
  end

  // Memory reads: stream bytes, then page-zero pointer bytes.
  always_comb
  begin
    mem_rd   = 1'b0;
    mem_addr = '0;
    case (state)
      ST_FETCH_B1:
      begin
        mem_rd   = (stream_bytes != 2'd0);
        mem_addr = fetch_pc;
      end
      ST_FETCH_B2:
      begin
        mem_rd   = 1'b1;
        mem_addr = fetch_pc + 16'h0001;
      end
      ST_PTR_HI:
      begin
        mem_rd   = 1'b1;
        mem_addr = {8'h00, byte1};
      end
      ST_PTR_LO:
      begin
        mem_rd   = 1'b1;
        mem_addr = {8'h00, byte1} + {15'h0000, ptr_word};
      end
      default:
      begin
        mem_rd   = 1'b0;
        mem_addr = '0;
      end
    endcase
  end

  // Effective address, computed when the last byte arrives.
  always_comb
  begin
    next_kind = EA_MEMORY;
    next_ea   = '0;
    case (cur_mode)
      MODE_INHERENT:          next_kind = EA_NONE;
      MODE_IMMEDIATE:         next_kind = EA_LITERAL;
      MODE_DIRECT_SHORT,
      MODE_BIT_DIRECT,
      // Short forms finish on their only stream byte, so it comes straight from the bus.
      MODE_BIT_DIRECT_REL:    next_ea = {8'h00, mem_rdata};
      MODE_DIRECT_LONG:       next_ea = {byte1, mem_rdata};
      MODE_INDEXED_NONE:      next_ea = {8'h00, cur_index};
      MODE_INDEXED_SHORT:
        next_ea = {8'h00, cur_index} + {8'h00, mem_rdata};
      MODE_INDEXED_LONG:
        next_ea = {byte1, mem_rdata} + {8'h00, cur_index};
      MODE_INDIRECT_SHORT,
      MODE_BIT_INDIRECT,
      MODE_BIT_INDIRECT_REL:  next_ea = {8'h00, mem_rdata};
      MODE_INDIRECT_LONG:     next_ea = {ptr_hi, mem_rdata};
      MODE_IND_INDEXED_SHORT:
        next_ea = {8'h00, mem_rdata} + {8'h00, cur_index};
      MODE_IND_INDEXED_LONG:
        next_ea = {ptr_hi, mem_rdata} + {8'h00, cur_index};
      MODE_RELATIVE_DIRECT,
      MODE_RELATIVE_INDIRECT:
      begin
        next_kind = EA_BRANCH;
        next_ea = next_pc + {{8{mem_rdata[7]}}, mem_rdata};
      end
      default:                next_kind = EA_NONE;
    endcase
  end

  // Result registers, loaded on the cycle that completes the address.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ea      <= '0;
      ea_kind <= EA_NONE;
      literal <= 8'h00;
    end
    else if (mem_valid && mem_rd && state != ST_PTR_HI &&
             !(state == ST_FETCH_B1 && (stream_bytes == 2'd2 || needs_ptr)))
    begin
      ea      <= next_ea;
      ea_kind <= next_kind;
      literal <= mem_rdata;
    end
    else if (state == ST_FETCH_B1 && stream_bytes == 2'd0)
    begin
      ea      <= next_ea;
      ea_kind <= next_kind;
    end
  end

  // Refusal flag for a long form requested by a read-modify-write operation.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      mode_error <= 1'b0;
    else
      mode_error <= (state == ST_IDLE) && start && rmw_op && long_form;
  end

  assign busy = (state != ST_IDLE);
  assign done = (state == ST_DONE);

  a_rmw_refused: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_IDLE && start && rmw_op && long_form) |=> (state == ST_IDLE && mode_error))
    else $error("Long form accepted for a read-modify-write operation.");

  a_short_page0: assert property (@(posedge sys_clk) disable iff (rst)
    (done && cur_mode == MODE_DIRECT_SHORT) |-> ((ea <= PAGE_ZERO_TOP) && (ea[7:0] == byte1)))
    else $error("Short direct address left page zero.");

  a_inherent_len: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_IDLE && start && mode == MODE_INHERENT) |=> ##1 (done && !$past(mem_rd)))
    else $error("Inherent mode did not finish without fetching.");

  a_ptr_order: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_PTR_HI && mem_valid) |=> (mem_addr == $past(mem_addr) + 16'h0001))
    else $error("Pointer low byte not read from the next address.");

  a_indexed_sum: assert property (@(posedge sys_clk) disable iff (rst)
    (done && cur_mode == MODE_INDEXED_SHORT) |-> (ea == {8'h00, cur_index} + {8'h00, byte1}))
    else $error("Short indexed address is not the unsigned sum.");

  a_next_pc: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_IDLE && start) |=> (next_pc == $past(pc_opcode) + 16'h0001
                                     + {13'h0000, instr_extra}))
    else $error("Advanced program counter is wrong.");

  a_stream_addr: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_FETCH_B2) |-> (mem_addr == fetch_pc + 16'h0001))
    else $error("Second address byte fetched from the wrong place.");

  a_done_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    done |=> !done)
    else $error("Done held for more than one cycle.");

endmodule // addressing_mode_ea_unit

/* hdl/ea_pkg.sv */
// Constants and types shared by the addressing mode and effective-address unit.
// Summary of operation
// - Seventeen addressing modes in seven groups.
// - Long modes reach the full 64 Kbyte space.
// - Short modes reach page zero, fewer bytes.
// - Read-modify-write operations refuse long forms.
// - Inherent instruction is one opcode byte only.
// - Immediate byte is the operand, not address.
// - Short direct uses one page-zero address byte.
// - Long direct takes two-byte sixteen-bit address.
// - Indexed address is index plus offset, unsigned.
// - Indexed without offset uses index as address.
// - Short indexed adds byte offset, up to 1FE.
// - Long indexed adds sixteen-bit offset to index.
// - Indirect reads pointer at page-zero pointer address.
// - Short indirect fetches a one-byte pointer.
// - Long indirect fetches two-byte pointer.
// - Relative base is PC after the branch.
// - Relative adds signed eight-bit displacement.
// - Indirect indexed adds index to fetched pointer.
package ea_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int MODE_COUNT = 17;
  localparam logic [15:0] PAGE_ZERO_TOP = 16'h00ff;

  typedef enum logic [4:0] {
    MODE_INHERENT,
    MODE_IMMEDIATE,
    MODE_DIRECT_SHORT,
    MODE_DIRECT_LONG,
    MODE_INDEXED_NONE,
    MODE_INDEXED_SHORT,
    MODE_INDEXED_LONG,
    MODE_INDIRECT_SHORT,
    MODE_INDIRECT_LONG,
    MODE_IND_INDEXED_SHORT,
    MODE_IND_INDEXED_LONG,
    MODE_RELATIVE_DIRECT,
    MODE_RELATIVE_INDIRECT,
    MODE_BIT_DIRECT,
    MODE_BIT_INDIRECT,
    MODE_BIT_DIRECT_REL,
    MODE_BIT_INDIRECT_REL
  } addr_mode_t;

  typedef enum logic [1:0] {
    EA_MEMORY,
    EA_LITERAL,
    EA_BRANCH,
    EA_NONE
  } ea_kind_t;

endpackage

/* tb/mem_model.sv */
// Behavioural program and data memory on the core bus, with adjustable read latency.
`timescale 1ns/1ps
module mem_model
  (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Read port.
    input  wire logic        mem_rd,
    input  wire logic [15:0] mem_addr,
    input  wire logic [1:0]  lat,
    output logic             mem_valid,
    output logic [7:0]       mem_rdata
  );
  logic [7:0] m [0:65535];
  logic [1:0] cnt;
  logic [7:0] junk;

  // Data shows only in the answering cycle; otherwise a pattern that keeps changing.
  assign mem_valid = mem_rd && (cnt == lat);
  assign mem_rdata = mem_valid ? m[mem_addr] : junk;

  always_ff @(posedge sys_clk)
  begin
    if (rst || !mem_rd || mem_valid)
      cnt <= 2'h0;
    else
      cnt <= cnt + 2'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      junk <= 8'ha5;
    else
      junk <= junk + 8'h5b;
  end
endmodule // mem_model

/* tb/tb_top.sv */
// Self-checking bench for the addressing mode and effective-address unit.
`timescale 1ns/1ps
module tb_top;
  import ea_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  addr_mode_t  mode = MODE_INHERENT;
  logic        use_second_index = 1'b0;
  logic        rmw_op = 1'b0;
  logic [15:0] pc_opcode = 16'h0;
  logic [7:0]  index_x = 8'h0;
  logic [7:0]  index_y = 8'h0;
  logic [1:0]  lat = 2'h0;
  logic        mem_rd, mem_valid, busy, done, mode_error;
  logic [15:0] mem_addr, ea, next_pc;
  logic [7:0]  mem_rdata, literal;
  logic [2:0]  instr_extra;
  ea_kind_t    ea_kind;
  logic [15:0] n_reads = 16'h0;
  logic [15:0] rd0;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;

  always #10 sys_clk = ~sys_clk;

  addressing_mode_ea_unit #(.ADDR_WIDTH(16)) dut (.sys_clk(sys_clk), .rst(rst), .start(start),
    .mode(mode), .use_second_index(use_second_index), .rmw_op(rmw_op), .pc_opcode(pc_opcode),
    .index_x(index_x), .index_y(index_y), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_valid(mem_valid), .mem_rdata(mem_rdata), .busy(busy), .done(done),
    .mode_error(mode_error), .ea_kind(ea_kind), .ea(ea), .literal(literal),
    .next_pc(next_pc), .instr_extra(instr_extra));

  mem_model mem (.sys_clk(sys_clk), .rst(rst), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .lat(lat), .mem_valid(mem_valid), .mem_rdata(mem_rdata));

  always @(posedge sys_clk)
  begin
    if (mem_rd === 1'b1 && mem_valid === 1'b1)
      n_reads <= n_reads + 16'h1;
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Issues one request and returns in the cycle that shows done or mode_error.
  task automatic go(input addr_mode_t md, input logic sec, input logic rmw,
                    input logic [15:0] pc, input logic [7:0] x, input logic [7:0] y,
                    input logic [1:0] l);
    @(posedge sys_clk);
    rd0 = n_reads;
    start <= 1'b1;
    mode <= md;
    use_second_index <= sec;
    rmw_op <= rmw;
    pc_opcode <= pc;
    index_x <= x;
    index_y <= y;
    lat <= l;
    @(posedge sys_clk);
    start <= 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge sys_clk);
      if (done === 1'b1 || mode_error === 1'b1)
        break;
    end
  endtask

  task automatic res(input logic [15:0] e, input ea_kind_t k, input logic [2:0] x,
                     input logic [15:0] r);
    chk("done", 16'h1, {15'h0, done});
    if (k == EA_MEMORY || k == EA_BRANCH)
      chk("ea", e, ea);
    chk("ea_kind", {14'h0, k}, {14'h0, ea_kind});
    chk("instr_extra", {13'h0, x}, {13'h0, instr_extra});
    chk("next_pc", pc_opcode + 16'h1 + {13'h0, x}, next_pc);
    chk("reads", r, n_reads - rd0);
  endtask

  task automatic t_inh_imm;
    go(MODE_INHERENT, 1'b0, 1'b0, 16'h1000, 8'h0, 8'h0, 2'h0);
    res(16'h0, EA_NONE, 3'h0, 16'h0);
    mem.m[16'h1001] = 8'h55;
    go(MODE_IMMEDIATE, 1'b0, 1'b0, 16'h1000, 8'h0, 8'h0, 2'h1);
    res(16'h0, EA_LITERAL, 3'h1, 16'h1);
    chk("literal", 16'h0055, {8'h0, literal});
  endtask

  task automatic t_direct;
    mem.m[16'h1001] = 8'hc3;
    go(MODE_DIRECT_SHORT, 1'b0, 1'b0, 16'h1000, 8'h0, 8'h0, 2'h0);
    res(16'h00c3, EA_MEMORY, 3'h1, 16'h1);
    mem.m[16'h1001] = 8'hbe;
    mem.m[16'h1002] = 8'hef;
    go(MODE_DIRECT_LONG, 1'b0, 1'b0, 16'h1000, 8'h0, 8'h0, 2'h2);
    res(16'hbeef, EA_MEMORY, 3'h2, 16'h2);
  endtask

  task automatic t_indexed;
    go(MODE_INDEXED_NONE, 1'b0, 1'b0, 16'h2000, 8'h9a, 8'h11, 2'h0);
    res(16'h009a, EA_MEMORY, 3'h0, 16'h0);
    go(MODE_INDEXED_NONE, 1'b1, 1'b0, 16'h2000, 8'h9a, 8'h11, 2'h0);
    res(16'h0011, EA_MEMORY, 3'h1, 16'h0);
    mem.m[16'h2001] = 8'hff;
    go(MODE_INDEXED_SHORT, 1'b0, 1'b0, 16'h2000, 8'hff, 8'h0, 2'h1);
    res(16'h01fe, EA_MEMORY, 3'h1, 16'h1);
    mem.m[16'h2001] = 8'h12;
    mem.m[16'h2002] = 8'hf0;
    go(MODE_INDEXED_LONG, 1'b1, 1'b0, 16'h2000, 8'h0, 8'h20, 2'h2);
    res(16'h1310, EA_MEMORY, 3'h2, 16'h2);
  endtask

  task automatic t_indirect;
    mem.m[16'h2001] = 8'h40;
    mem.m[16'h0040] = 8'h77;
    go(MODE_INDIRECT_SHORT, 1'b0, 1'b0, 16'h2000, 8'h0, 8'h0, 2'h1);
    res(16'h0077, EA_MEMORY, 3'h2, 16'h2);
    go(MODE_IND_INDEXED_SHORT, 1'b0, 1'b0, 16'h2000, 8'hf0, 8'h0, 2'h0);
    res(16'h0167, EA_MEMORY, 3'h2, 16'h2);
    mem.m[16'h2001] = 8'h50;
    mem.m[16'h0050] = 8'hab;
    mem.m[16'h0051] = 8'hcd;
    go(MODE_INDIRECT_LONG, 1'b0, 1'b0, 16'h2000, 8'h0, 8'h0, 2'h2);
    res(16'habcd, EA_MEMORY, 3'h2, 16'h3);
    go(MODE_IND_INDEXED_LONG, 1'b1, 1'b0, 16'h2000, 8'h0, 8'hff, 2'h0);
    res(16'haccc, EA_MEMORY, 3'h2, 16'h3);
  endtask

  task automatic t_relative;
    mem.m[16'h3001] = 8'h80;
    go(MODE_RELATIVE_DIRECT, 1'b0, 1'b0, 16'h3000, 8'h0, 8'h0, 2'h0);
    res(16'h2f82, EA_BRANCH, 3'h1, 16'h1);
    mem.m[16'h3001] = 8'h7f;
    go(MODE_RELATIVE_DIRECT, 1'b0, 1'b0, 16'h3000, 8'h0, 8'h0, 2'h1);
    res(16'h3081, EA_BRANCH, 3'h1, 16'h1);
    mem.m[16'h3001] = 8'h60;
    mem.m[16'h0060] = 8'hfe;
    go(MODE_RELATIVE_INDIRECT, 1'b0, 1'b0, 16'h3000, 8'h0, 8'h0, 2'h2);
    res(16'h3001, EA_BRANCH, 3'h2, 16'h2);
  endtask

  task automatic t_bit;
    go(MODE_BIT_INDIRECT, 1'b0, 1'b0, 16'h3000, 8'h0, 8'h0, 2'h0);
    res(16'h00fe, EA_MEMORY, 3'h2, 16'h2);
    go(MODE_BIT_INDIRECT_REL, 1'b0, 1'b0, 16'h3000, 8'h0, 8'h0, 2'h1);
    res(16'h00fe, EA_MEMORY, 3'h3, 16'h2);
    mem.m[16'h3001] = 8'h33;
    go(MODE_BIT_DIRECT, 1'b0, 1'b0, 16'h3000, 8'h0, 8'h0, 2'h0);
    res(16'h0033, EA_MEMORY, 3'h1, 16'h1);
    go(MODE_BIT_DIRECT_REL, 1'b0, 1'b0, 16'h3000, 8'h0, 8'h0, 2'h2);
    res(16'h0033, EA_MEMORY, 3'h2, 16'h1);
  endtask

  task automatic t_rmw;
    addr_mode_t lng [4] = '{MODE_DIRECT_LONG, MODE_INDEXED_LONG, MODE_INDIRECT_LONG,
                            MODE_IND_INDEXED_LONG};
    foreach (lng[j])
    begin
      go(lng[j], 1'b0, 1'b1, 16'h3000, 8'h0, 8'h0, 2'h0);
      chk("mode_error", 16'h1, {15'h0, mode_error});
      chk("busy", 16'h0, {15'h0, busy});
    end
    go(MODE_DIRECT_SHORT, 1'b0, 1'b1, 16'h3000, 8'h0, 8'h0, 2'h1);
    res(16'h0033, EA_MEMORY, 3'h1, 16'h1);
  endtask

  // Aborts a stream-byte fetch by a mid-run reset, then checks that a new request still works.
  task automatic t_reset;
    mem.m[16'h3001] = 8'h60;
    @(posedge sys_clk);
    start <= 1'b1;
    mode <= MODE_INDIRECT_LONG;
    rmw_op <= 1'b0;
    pc_opcode <= 16'h3000;
    lat <= 2'h2;
    @(posedge sys_clk);
    start <= 1'b0;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk("rst busy", 16'h0, {15'h0, busy});
    chk("rst mem_rd", 16'h0, {15'h0, mem_rd});
    chk("rst mode_error", 16'h0, {15'h0, mode_error});
    chk("rst ea", 16'h0, ea);
    chk("rst ea_kind", {14'h0, EA_NONE}, {14'h0, ea_kind});
    chk("rst literal", 16'h0, {8'h0, literal});
    chk("rst next_pc", 16'h0, next_pc);
    chk("rst instr_extra", 16'h0, {13'h0, instr_extra});
    go(MODE_INDIRECT_SHORT, 1'b0, 1'b0, 16'h3000, 8'h0, 8'h0, 2'h1);
    res(16'h00fe, EA_MEMORY, 3'h2, 16'h2);
  endtask

  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_inh_imm();
    t_direct();
    t_indexed();
    t_indirect();
    t_relative();
    t_bit();
    t_rmw();
    t_reset();
    conclude();
  end
endmodule // tb_top
